// ==== hdl/cpf_regs.v ====
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "cpf_consts.vh"
// Operation
// - pd bit 0: front end on, scanned
// - pd bit 1: front end off, never scanned
// - four-channel: upper-channel writes change nothing
// - four-channel: absent-channel bits read ones
// - bits 7:6 daisy-chain id, reset 0
// - bits 5 and 3 read zero
// - bit 4 enables alarm, reset 0
// - bits 2:0 output word format, reset 0
// - formats add channel, device id, range
// - all channels down: data invalid
module cpf_regs #(
  parameter NUM_CHAN = 8,
  parameter FOUR_CHAN = 0
) (
  input wire mclk_in,
  input wire reset_n_in,
  input wire hsel_in,
  input wire [11:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output wire hreadyout_out,
  output wire hresp_out,
  output wire [NUM_CHAN-1:0] afe_power_on_out,
  output wire [NUM_CHAN-1:0] scan_allow_out,
  output reg data_invalid_out,
  output reg [1:0] device_id_out,
  output reg alarm_enable_out,
  output reg [2:0] output_word_format_out,
  output reg append_chan_addr_out,
  output reg append_device_id_out,
  output reg append_range_out
);

  // which channels exist in this build; absent ones are masked everywhere
  localparam [NUM_CHAN-1:0] PRESENT = FOUR_CHAN ? {{(NUM_CHAN-4){1'b0}}, 4'hF}
                                                : {NUM_CHAN{1'b1}};

  reg [NUM_CHAN-1:0] chan_pd_q;
  reg [1:0] dev_id_q;
  reg alarm_en_q;
  reg [2:0] fmt_q;
  reg wr_pend_q;
  reg [11:0] addr_q;
  reg [NUM_CHAN-1:0] chan_pd_rd;

  wire [NUM_CHAN-1:0] power_on;
  wire [NUM_CHAN-1:0] scan_ok;
  wire all_down;
  wire [7:0] feature_rd;
  wire [2:0] fmt_eff;
  wire addr_phase;
  wire sel_chan_pd;
  wire sel_feature;
  wire wr_chan_pd;
  wire wr_feature;
  wire [NUM_CHAN-1:0] chan_pd_d;
  wire [1:0] dev_id_d;
  wire alarm_en_d;
  wire [2:0] fmt_d;

  // zero-wait slave: every transfer finishes in its first data-phase cycle
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign addr_phase = hsel_in & hready_in &
                      (htrans_in == `CPF_HTRANS_NONSEQ || htrans_in == `CPF_HTRANS_SEQ);
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_phase & hwrite_in;
      if (addr_phase) begin
        addr_q <= haddr_in;
      end
    end
  end

  assign sel_chan_pd = (addr_q == `CPF_ADDR_CHAN_PD);
  assign sel_feature = (addr_q == `CPF_ADDR_FEATURE);
  // a write lands at the end of its data phase, while hwdata still stands
  assign wr_chan_pd = wr_pend_q & sel_chan_pd;
  assign wr_feature = wr_pend_q & sel_feature;

  // absent bits keep their reset value so they never steer anything
  assign chan_pd_d = (hwdata_in[NUM_CHAN-1:0] & PRESENT) |
                     (chan_pd_q & ~PRESENT);
  assign dev_id_d = hwdata_in[`CPF_DEV_HI:`CPF_DEV_LO];
  assign alarm_en_d = hwdata_in[`CPF_ALARM_EN];
  // bits 5 and 3 have no storage, so a stray one from the host is dropped
  assign fmt_d = hwdata_in[`CPF_FMT_HI:`CPF_FMT_LO];

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chan_pd_q <= `CPF_RST_CHAN_PD;
    end else if (wr_chan_pd) begin
      chan_pd_q <= chan_pd_d;
    end
  end

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dev_id_q <= 2'h0;
    end else if (wr_feature) begin
      dev_id_q <= dev_id_d;
    end
  end

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alarm_en_q <= 1'b0;
    end else if (wr_feature) begin
      alarm_en_q <= alarm_en_d;
    end
  end

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fmt_q <= 3'h0;
    end else if (wr_feature) begin
      fmt_q <= fmt_d;
    end
  end

  always @* begin
    chan_pd_rd = chan_pd_q | ~PRESENT;
  end
  assign feature_rd = {dev_id_q, 1'b0, alarm_en_q, 1'b0, fmt_q};
  always @* begin
    case (addr_q)
      `CPF_ADDR_CHAN_PD: hrdata_out = {{(32-NUM_CHAN){1'b0}}, chan_pd_rd};
      `CPF_ADDR_FEATURE: hrdata_out = {24'h000000, feature_rd};
      `CPF_ADDR_VARIANT: hrdata_out = {31'h00000000, FOUR_CHAN != 0};
      default: hrdata_out = 32'h00000000;
    endcase
  end

  // codes above 011 fall back to the bare result word
  assign fmt_eff = (fmt_q > `CPF_FMT_RANGE) ? `CPF_FMT_RESULT : fmt_q;

  // control outputs are registered copies, one cycle behind the fields
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      device_id_out <= 2'h0;
    end else begin
      device_id_out <= dev_id_q;
    end
  end

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alarm_enable_out <= 1'b0;
    end else begin
      alarm_enable_out <= alarm_en_q;
    end
  end

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      output_word_format_out <= 3'h0;
    end else begin
      output_word_format_out <= fmt_eff;
    end
  end

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      append_chan_addr_out <= 1'b0;
    end else begin
      append_chan_addr_out <= (fmt_eff >= `CPF_FMT_CHAN);
    end
  end

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      append_device_id_out <= 1'b0;
    end else begin
      append_device_id_out <= (fmt_eff >= `CPF_FMT_DEV);
    end
  end

  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      append_range_out <= 1'b0;
    end else begin
      append_range_out <= (fmt_eff == `CPF_FMT_RANGE);
    end
  end

  // registering the flag keeps a glitch on the mask from reaching the output
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_invalid_out <= 1'b0;
    end else begin
      data_invalid_out <= all_down;
    end
  end

  cpf_chan_ctl #(
    .NUM_CHAN(NUM_CHAN)
  ) u_chan (
    .pd_bits_in(chan_pd_q),
    .present_in(PRESENT),
    .afe_power_on_out(power_on),
    .scan_allow_out(scan_ok),
    .all_down_out(all_down)
  );
  assign afe_power_on_out = power_on;
  assign scan_allow_out = scan_ok;

endmodule // cpf_regs

// ==== hdl/cpf_consts.vh ====
`ifndef CPF_CONSTS_VH
`define CPF_CONSTS_VH
// register byte addresses, printed offsets 02h and 03h are index values
`define CPF_IDX_CHAN_PD 8'h02
`define CPF_IDX_FEATURE 8'h03
`define CPF_ADDR_CHAN_PD 12'h008
`define CPF_ADDR_FEATURE 12'h00C
`define CPF_ADDR_VARIANT 12'h010
// reset values
`define CPF_RST_CHAN_PD 8'h00
`define CPF_RST_FEATURE 8'h00
// feature field positions
`define CPF_DEV_HI 7
`define CPF_DEV_LO 6
`define CPF_ZERO5 5
`define CPF_ALARM_EN 4
`define CPF_ZERO3 3
`define CPF_FMT_HI 2
`define CPF_FMT_LO 0
// output word format codes
`define CPF_FMT_RESULT 3'h0
`define CPF_FMT_CHAN 3'h1
`define CPF_FMT_DEV 3'h2
`define CPF_FMT_RANGE 3'h3
// ahb encodings
`define CPF_HTRANS_NONSEQ 2'h2
`define CPF_HTRANS_SEQ 2'h3
`endif

// ==== hdl/cpf_chan_ctl.v ====
`timescale 1ns/1ps
`include "cpf_consts.vh"
// per-channel front-end power and scan eligibility
module cpf_chan_ctl #(
  parameter NUM_CHAN = 8
) (
  input wire [NUM_CHAN-1:0] pd_bits_in,
  input wire [NUM_CHAN-1:0] present_in,
  output wire [NUM_CHAN-1:0] afe_power_on_out,
  output wire [NUM_CHAN-1:0] scan_allow_out,
  output wire all_down_out
);
  genvar i;
  generate
    for (i = 0; i < NUM_CHAN; i = i + 1) begin : g_chan
      // absent channels stay off whatever the stored bit says
      assign afe_power_on_out[i] = present_in[i] & ~pd_bits_in[i];
      assign scan_allow_out[i] = present_in[i] & ~pd_bits_in[i];
    end
  endgenerate
  assign all_down_out = ~|(present_in & ~pd_bits_in);
endmodule // cpf_chan_ctl

// ==== sim/cpf_props.sv ====
`timescale 1ns/1ps
module cpf_props #(parameter NUM_CHAN = 8) (
  input mclk_in, reset_n_in, hsel_in, hwrite_in, hready_in, data_invalid_out,
  input alarm_enable_out, append_chan_addr_out, append_device_id_out, append_range_out,
  input [1:0] htrans_in, device_id_out,
  input [2:0] output_word_format_out,
  input [11:0] haddr_in,
  input [31:0] hwdata_in, hrdata_out,
  input [NUM_CHAN-1:0] afe_power_on_out, scan_allow_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  wire go = hsel_in && hready_in && htrans_in[1];
  // write data stands one cycle after the address phase
  sequence wr_s(a);
    go && hwrite_in && haddr_in == a ##1 1'b1;
  endsequence
  pwr_follow_a: assert property (wr_s(12'h008) |=>
    afe_power_on_out == {4'h0, ~$past(hwdata_in[3:0])}) else $error("power mask wrong");
  scan_same_a: assert property (scan_allow_out == afe_power_on_out)
    else $error("scan mask wrong");
  all_down_a: assert property (data_invalid_out == $past(afe_power_on_out == 8'h00))
    else $error("invalid flag wrong");
  dev_id_a: assert property (wr_s(12'h00C) |=> ##1 device_id_out == $past(hwdata_in[7:6], 2))
    else $error("device id wrong");
  alarm_en_a: assert property (wr_s(12'h00C) |=> ##1 alarm_enable_out == $past(hwdata_in[4], 2))
    else $error("alarm enable wrong");
  fmt_map_a: assert property (wr_s(12'h00C) |=> ##1
    output_word_format_out == ($past(hwdata_in[2], 2) ? 3'h0 : $past(hwdata_in[2:0], 2)))
    else $error("format wrong");
  append_map_a: assert property (append_range_out == (output_word_format_out == 3'h3) &&
    append_chan_addr_out == (output_word_format_out != 3'h0) &&
    append_device_id_out == output_word_format_out[1]) else $error("append flags wrong");
  zero_bits_a: assert property (go && !hwrite_in && haddr_in == 12'h00C |=>
    hrdata_out[5] == 1'b0 && hrdata_out[3] == 1'b0) else $error("reserved bits set");
endmodule // cpf_props

// ==== sim/cpf_host.sv ====
`timescale 1ns/1ps
module cpf_host (
  input mclk_in, hready_in,
  input [31:0] hrdata_in,
  output reg hsel_out, hwrite_out,
  output reg [1:0] htrans_out,
  output reg [2:0] hsize_out,
  output reg [11:0] haddr_out,
  output reg [31:0] hwdata_out
);
  initial {hsel_out, hwrite_out, htrans_out, haddr_out, hwdata_out, hsize_out} = 51'h2;
  task wt;
    @(posedge mclk_in);
    for (int n = 0; hready_in !== 1'b1; n++) begin
      if (n == 64) testbench.report_and_stop(1);
      @(posedge mclk_in);
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r);
    hsel_out <= 1'b1;
    haddr_out <= a;
    htrans_out <= 2'h2;
    hwrite_out <= w;
    wt();
    htrans_out <= 2'h0;
    hwdata_out <= (a == 12'h00C) ? d & 32'hFFFFFFD7 : d;
    wt();
    r = hrdata_in;
    // released data lines must not look like the last value
    hwdata_out <= ~d;
  endtask
endmodule // cpf_host

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic mclk_in = 0;
  logic reset_n_in = 0;
  wire hsel_in, hwrite_in, hreadyout_out, hresp_out, data_invalid_out, alarm_enable_out;
  wire append_chan_addr_out, append_device_id_out, append_range_out;
  wire [1:0] htrans_in, device_id_out;
  wire [2:0] hsize_in, output_word_format_out;
  wire [11:0] haddr_in;
  wire [31:0] hwdata_in, hrdata_out;
  wire [7:0] afe_power_on_out, scan_allow_out;
  wire hready_in = hreadyout_out;
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] r;
  initial forever #20 mclk_in = ~mclk_in;
  cpf_regs #(.FOUR_CHAN(1)) cpf_regs_i (.*);
  cpf_host cpf_host_i (.mclk_in(mclk_in), .hready_in(hready_in), .hrdata_in(hrdata_out),
    .hsel_out(hsel_in), .hwrite_out(hwrite_in), .htrans_out(htrans_in), .hsize_out(hsize_in),
    .haddr_out(haddr_in), .hwdata_out(hwdata_in));
  task report_and_stop(input bit hung);
    err_total += hung;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    cpf_host_i.xfer(0, 12'h008, 0, r);
    chk(r, 32'hF0);
    chk(afe_power_on_out, 8'h0F);
    chk({hresp_out, hreadyout_out}, 2'h1);
    cpf_host_i.xfer(0, 12'h00C, 0, r);
    chk(r, 32'h00);
    cpf_host_i.xfer(0, 12'h010, 0, r);
    chk(r, 32'h01);
    cpf_host_i.xfer(1, 12'h008, 32'hF5, r);
    cpf_host_i.xfer(0, 12'h008, 0, r);
    chk(r, 32'hF5);
    chk({scan_allow_out, data_invalid_out}, 9'h014);
    cpf_host_i.xfer(1, 12'h008, 32'h0F, r);
    cpf_host_i.xfer(0, 12'h020, 0, r);
    chk({r, afe_power_on_out, data_invalid_out}, 1);
    $display("power down test done");
    for (int i = 0; i < 8; i++) begin
      cpf_host_i.xfer(1, 12'h00C, {i[1:0], 2'h0 | i[0], 1'b0, i[2:0]}, r);
      cpf_host_i.xfer(0, 12'h00C, 0, r);
      chk(r, {i[1:0], 1'b0, i[0], 1'b0, i[2:0]});
      chk({device_id_out, alarm_enable_out}, {i[1:0], i[0]});
      chk(output_word_format_out, i > 3 ? 0 : i);
      chk({append_chan_addr_out, append_device_id_out, append_range_out},
        i > 3 ? 0 : {i != 0, i[1], i == 3});
    end
    $display("feature test done");
    // reset again mid-run: every field must fall back to its reset value
    reset_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    cpf_host_i.xfer(0, 12'h00C, 0, r);
    chk(r, 32'h00);
    cpf_host_i.xfer(0, 12'h008, 0, r);
    chk(r, 32'hF0);
    chk({output_word_format_out, alarm_enable_out, data_invalid_out}, 5'h00);
    $display("reset test done");
    report_and_stop(0);
  end
endmodule // testbench
bind cpf_regs cpf_props #(.NUM_CHAN(NUM_CHAN)) cpf_props_i (.*);
